/* File: dv/demod_ctl_asserts.sv */
`timescale 1ns/1ps
module demod_ctl_asserts (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic        stage_zero_receiver_control_out,
  input wire logic        stage_zero_receiver_control_oe_out,
  input wire logic [6:0]  receiver_stage_controls_out,
  input wire logic [6:0]  receiver_stage_controls_oe_out,
  input wire logic        reference_clock_output_out
);
  wire       ext = stage_zero_receiver_control_oe_out;
  wire       rc  = reference_clock_output_out;
  wire [6:0] sc  = receiver_stage_controls_out;
  wire [7:0] ln  = {sc, stage_zero_receiver_control_out};
  logic [11:0] hc_r;
  logic        arm_r;
  // ==========================================================================
  // Cycles since the last reference edge; a mode change disarms the check.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hc_r  <= 12'h000;
      arm_r <= 1'b0;
    end else if ($changed(rc) || !ext) begin
      hc_r  <= 12'h000;
      arm_r <= ext;
    end else begin
      hc_r  <= hc_r + 12'h001;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  property p_ack_next; s_req |=> wb_ack_out; endproperty
  property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
  property p_ack_cause; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in); endproperty
  property p_dat_hold; !wb_ack_out && !(wb_cyc_in && wb_stb_in) |=> $stable(wb_dat_out);
  endproperty
  property p_s0_int; !ext |-> !stage_zero_receiver_control_out; endproperty
  property p_oe_all; receiver_stage_controls_oe_out == 7'h7F; endproperty
  property p_thermo;
    ext ? ((ln & (ln + 8'h01)) == 8'h00) : ((sc & (sc + 7'h01)) == 7'h00);
  endproperty
  property p_step; $changed(ln) |-> $onehot(ln ^ $past(ln)); endproperty
  property p_ref_ext; $changed(rc) && arm_r && ext |-> hc_r inside {[1295:1310]};
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after a request");
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed while idle");
  a_s0_int: assert property (p_s0_int)
    else $error("stage zero driven high in internal mode");
  a_oe_all: assert property (p_oe_all)
    else $error("stage line enable dropped");
  a_thermo: assert property (p_thermo)
    else $error("stage lines not contiguous");
  a_step: assert property (p_step)
    else $error("more than one stage moved at once");
  a_ref_ext: assert property (p_ref_ext)
    else $error("external reference half period wrong");
endmodule
bind demod_mode_clock_and_rx_control demod_ctl_asserts i_demod_ctl_asserts (
  .sys_clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .wb_dat_out,
  .stage_zero_receiver_control_out, .stage_zero_receiver_control_oe_out,
  .receiver_stage_controls_out, .receiver_stage_controls_oe_out,
  .reference_clock_output_out);

/* File: dv/demod_mode_clock_and_rx_control_tb.sv */
`timescale 1ns/1ps
`include "demod_regs.svh"
module demod_mode_clock_and_rx_control_tb;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, lbat_req = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, irq, s0, s0_oe, limited_if_input, msb, lsb, lbat, refclk;
  logic [6:0]  sc, sc_oe;
  logic [3:0]  fbw;
  logic [1:0]  sym = 2'h2;
  int          n_mismatch = 0, checks_done = 0, cyc_n = 0;
  demod_mode_clock_and_rx_control #(.MINUTE_TICKS_INT(8), .MINUTE_TICKS_EXT(8))
    i_demod_mode_clock_and_rx_control (.sys_clk_in(clk), .reset_n_in(rst_n),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq),
    .limited_if_input_in(limited_if_input), .stage_zero_receiver_control_out(s0),
    .stage_zero_receiver_control_oe_out(s0_oe), .receiver_stage_controls_out(sc),
    .receiver_stage_controls_oe_out(sc_oe), .symbol_msb_input_in(msb),
    .symbol_lsb_input_in(lsb), .low_battery_input_in(lbat),
    .reference_clock_output_out(refclk), .filter_bw_code_out(fbw));
  rx_front_end_model i_rx_front_end_model (.sys_clk_in(clk), .pin_driven_in(s0_oe),
    .pin_level_in(s0), .sym_in(sym), .low_bat_in(lbat_req), .if_out(limited_if_input),
    .msb_out(msb), .lsb_out(lsb), .low_bat_out(lbat));
  // ==========================================================================
  // Clock, hang guard and shared tasks.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 90000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read data is taken only at the edge where ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wait_ln(input logic [7:0] e);
    for (int n = 0; n < 30000 && {sc, s0} !== e; n++) @(posedge clk);
    chk(32'({sc, s0}), 32'(e));
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    logic [7:0]  ra[5] = '{`ADR_CTRL, `ADR_FILTER, `ADR_STAGE_TIME, `ADR_MASK, `ADR_SEQ_CMD};
    logic [31:0] rv[5] = '{32'h0, 32'h21, 32'h10, 32'h0, 32'h0};
    chk(32'({s0_oe, sc_oe}), 32'h7F);
    for (int i = 0; i < 5; i++) begin
      wb(0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    chk(32'(fbw), 32'h1);
    wb(1, 8'h20, 32'hFFFFFFFF);
    wb(0, 8'h20, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic per(input int k, output int n);
    logic p;
    while (refclk !== 1'b0) @(posedge clk);
    while (refclk !== 1'b1) @(posedge clk);
    p = 1'b1;
    n = 0;
    for (int r = 0; r < k && n < 20000; n++) begin
      @(posedge clk);
      if (refclk === 1'b1 && p === 1'b0) r++;
      p = refclk;
    end
  endtask
  task automatic t_ref_int();
    int   n;
    logic hi;
    wb(1, `ADR_CTRL, 32'h18);
    per(1, n);
    chk(32'(n), 32'd2500);
    wb(1, `ADR_CTRL, 32'h08);
    per(6, n);
    chk(32'(n), 32'd15625);
    wb(1, `ADR_CTRL, 32'h00);
    hi = 0;
    repeat (3000) @(posedge clk) hi |= refclk;
    chk(32'(hi), 32'h0);
  endtask
  task automatic t_seq(input logic ext);
    lbat_req <= !ext;
    wb(1, `ADR_MASK, 32'h0);
    wb(1, `ADR_STAGE_TIME, 32'h1);
    wb(1, `ADR_CTRL, ext ? 32'hD : 32'h0);
    wb(0, `ADR_STATUS, 32'h0);
    wb(1, `ADR_SEQ_CMD, 32'h1);
    wait_ln(ext ? 8'hFF : 8'hFE);
    for (int n = 0; n < 500; n++) begin
      wb(0, `ADR_STATE, 32'h0);
      if (q[8] === 1'b0) break;
    end
    chk(32'(irq), 32'h0);
    wb(1, `ADR_MASK, 32'h1);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    wb(0, `ADR_STATUS, 32'h0);
    chk(q & 32'h3, {30'h0, !ext, 1'b1});
    @(posedge clk);
    chk(32'(irq), 32'h0);
    if (ext) begin
      chk(32'(s0_oe), 32'h1);
      chk(32'(fbw), 32'h2);
      wb(0, `ADR_STATE, 32'h0);
      chk(32'(q[12:10]), {29'h0, 1'b1, sym});
    end
    wb(1, `ADR_SEQ_CMD, 32'h2);
    wait_ln(8'h00);
  endtask
  task automatic t_minute();
    logic [15:0] m;
    int          t0;
    wb(0, `ADR_MINUTES, 32'h0);
    repeat (2) begin
      m  = q[15:0];
      t0 = cyc_n;
      for (int n = 0; n < 3000 && q[15:0] === m; n++) wb(0, `ADR_MINUTES, 32'h0);
    end
    chk(32'(q[15:0] - m), 32'h1);
    chk(32'(cyc_n - t0 inside {[4996:5004]}), 32'h1);
    wb(0, `ADR_STATUS, 32'h0);
    chk(q & 32'h4, 32'h4);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ref_int();
    t_seq(1'b0);
    t_minute();
    t_seq(1'b1);
    results();
  end
endmodule

/* File: dv/rx_front_end_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Radio front end: limited IF, symbol bits and low-battery detector.
module rx_front_end_model (
  input  wire logic       sys_clk_in,
  input  wire logic       pin_driven_in,
  input  wire logic       pin_level_in,
  input  wire logic [1:0] sym_in,
  input  wire logic       low_bat_in,
  output logic            if_out,
  output logic            msb_out,
  output logic            lsb_out,
  output logic            low_bat_out
);
  logic [6:0] cnt_r = 7'h00;
  logic       if_r  = 1'b0;
  // A toggle every 110 cycles gives a limited IF near 455 kHz.
  always_ff @(posedge sys_clk_in) begin
    cnt_r <= (cnt_r == 7'h6D) ? 7'h00 : cnt_r + 7'h01;
    if (cnt_r == 7'h6D) if_r <= ~if_r;
  end
  // The radio lets go of the shared pin while the decoder drives it.
  assign if_out      = pin_driven_in ? pin_level_in : if_r;
  assign msb_out     = sym_in[1];
  assign lsb_out     = sym_in[0];
  assign low_bat_out = low_bat_in;
endmodule

/* File: pkg/demod_pkg.sv */
package demod_pkg;

  // ========================================================================
  // Channel bit rate as stored in the control register.
  typedef enum logic [1:0] {
    RATE_1600,
    RATE_3200,
    RATE_6400,
    RATE_SPARE
  } rate_e;

  // ========================================================================
  // Receiver stage sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WARM,
    SEQ_SHUT
  } seq_state_e;

endpackage

/* File: pkg/demod_regs.svh */
`ifndef DEMOD_REGS_SVH
`define DEMOD_REGS_SVH

// ====================
// Register byte offsets.
`define ADR_CTRL          8'h00
`define ADR_SEQ_CMD       8'h04
`define ADR_STAGE_TIME    8'h08
`define ADR_STATUS        8'h0C
`define ADR_MASK          8'h10
`define ADR_STATE         8'h14
`define ADR_MINUTES       8'h18
`define ADR_FILTER        8'h1C

// ====================
// Control register fields.
`define CTRL_W            6
`define CTRL_EXT_BIT      0
`define CTRL_RATE_LSB     1
`define CTRL_RATE_MSB     2
`define CTRL_REF_EN_BIT   3
`define CTRL_REF40_BIT    4
`define CTRL_IF140_BIT    5
`define CTRL_RESET        6'h00

// ====================
// Sequence command bits.
`define CMD_WARM_BIT      0
`define CMD_SHUT_BIT      1

// ====================
// Interrupt status and mask bits.
`define IRQ_W             4
`define IRQ_SEQ_DONE_BIT  0
`define IRQ_LOW_BAT_BIT   1
`define IRQ_MINUTE_BIT    2
`define IRQ_SYMBOL_BIT    3
`define IRQ_RESET         4'h0

// ====================
// State register fields.
`define ST_LINES_LSB      0
`define ST_LINES_MSB      7
`define ST_BUSY_BIT       8
`define ST_LOW_BAT_BIT    9
`define ST_SYM_LSB        10
`define ST_SYM_MSB        11
`define ST_EXT_BIT        12
`define ST_EDGES_LSB      16
`define ST_EDGES_MSB      27

// ====================
// Filter register fields and other reset values.
`define FILT_LOW_LSB      0
`define FILT_LOW_MSB      3
`define FILT_HIGH_LSB     4
`define FILT_HIGH_MSB     7
`define FILT_RESET        8'h21
`define STAGE_TIME_RESET  16'h0010

// ====================
// Receiver stage line indices.
`define STAGE_TOP         3'h7
`define STAGE_EXT_FIRST   3'h0
`define STAGE_INT_FIRST   3'h1

// ====================
// Frequencies in Hz and times in seconds.
`define SYS_HZ            28'd100000000
`define OSC_INT_HZ        28'd160000
`define OSC_EXT_HZ        28'd76800
`define REF_FRAC_HZ       20'd38400
`define REF_FRAC_MOD_HZ   20'd160000
`define SYM_LOW_HZ        28'd1600
`define SYM_HIGH_HZ       28'd3200
`define MINUTE_S          28'd60

`endif

/* File: pkg/rx_seq_if.sv */
`timescale 1ns/1ps
interface rx_seq_if;
  logic        warm_go;
  logic        shut_go;
  logic        osc_tick;
  logic        ext_mode;
  logic        low_bat;
  logic [15:0] stage_ticks;
  logic [7:0]  lines;
  logic        busy;
  logic        done;
  logic        low_bat_hit;

  modport ctrl (
    output warm_go, shut_go, osc_tick, ext_mode, low_bat, stage_ticks,
    input  lines, busy, done, low_bat_hit
  );

  modport seq (
    input  warm_go, shut_go, osc_tick, ext_mode, low_bat, stage_ticks,
    output lines, busy, done, low_bat_hit
  );
endinterface

/* File: rtl/demod_mode_clock_and_rx_control.sv */
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "demod_regs.svh"
// Behaviour
// (RULE1) Internal mode takes one-bit limited IF input.
// (RULE2) Internal mode drives seven staged receiver controls.
// (RULE3) Low battery sampled during control sequences.
// (RULE4) One-minute interval timer for host timekeeping.
// (RULE5) Internal mode needs a 160 kHz oscillator.
// (RULE6) Internal reference: 38.4 kHz fractional or 40 kHz.
// (RULE7) External mode takes two-bit four-level symbols.
// (RULE8) External mode drives eight staged receiver controls.
// (RULE9) Filter bandwidth setting per symbol rate.
// (RULE10) External mode needs a 76.8 kHz oscillator.
// (RULE11) External reference output is 38.4 kHz when enabled.
// (RULE12) Demodulator timing follows 1600, 3200, 6400 bps.
// (RULE13) Shared pin: stage zero output or IF input.
// (RULE14) Symbol inputs are most and least significant bits.
// (RULE15) External detector drives the low battery input.
// (RULE16) Mode bit steers pin, lines and reference divider.
// (RULE17) External reference divides by two; disable holds low.
module demod_mode_clock_and_rx_control #(
  parameter int unsigned MINUTE_TICKS_INT = `MINUTE_S * `OSC_INT_HZ,
  parameter int unsigned MINUTE_TICKS_EXT = `MINUTE_S * `OSC_EXT_HZ
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             irq_out,
  input  wire logic        limited_if_input_in,
  output logic             stage_zero_receiver_control_out,
  output logic             stage_zero_receiver_control_oe_out,
  output logic      [6:0]  receiver_stage_controls_out,
  output logic      [6:0]  receiver_stage_controls_oe_out,
  input  wire logic        symbol_msb_input_in,
  input  wire logic        symbol_lsb_input_in,
  input  wire logic        low_battery_input_in,
  output logic             reference_clock_output_out,
  output logic      [3:0]  filter_bw_code_out
);

  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    logic [7:0]         filt;
    logic [15:0]        stage_time;
    logic [`IRQ_W-1:0]  status;
    logic [`IRQ_W-1:0]  mask;
    logic               ack;
    logic [31:0]        rdata;
    logic               warm_go;
    logic               shut_go;
    logic [23:0]        minute_cnt;
    logic [15:0]        minutes;
    logic [7:0]         sym_cnt;
    logic [1:0]         symbol;
    logic [11:0]        edge_acc;
    logic [11:0]        edges;
    logic [3:0]         filt_code;
    logic [1:0]         lb_sync;
    logic [1:0]         msb_sync;
    logic [1:0]         lsb_sync;
    logic [2:0]         if_sync;
  } top_s;

  top_s              st_r;
  top_s              st_nxt;
  logic              osc_tick;
  logic              ext_mode;
  logic              high_rate;
  logic              req;
  logic              minute_ev;
  logic              sym_ev;
  logic [`IRQ_W-1:0] events;
  logic [`IRQ_W-1:0] rd_clear;
  logic [31:0]       state_word;
  logic [23:0]       minute_last;
  logic [7:0]        sym_last;

  rx_seq_if seq_bus ();

  // ====================
  // Decoding helpers.
  // Only the 6400 bps rate runs at the higher symbol rate of 3200 per second.
  function automatic logic is_high_rate(input logic [1:0] rate);
    return demod_pkg::rate_e'(rate) == demod_pkg::RATE_6400;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Oscillator ticks per symbol, derived from the rates.
  function automatic logic [7:0] sym_period(input logic ext, input logic high);
    logic [27:0] osc;
    logic [27:0] per;
    osc = ext ? `OSC_EXT_HZ : `OSC_INT_HZ;
    per = osc / (high ? `SYM_HIGH_HZ : `SYM_LOW_HZ);
    return per[7:0];
  endfunction

  // ====================
  // Mode decoding.
  assign ext_mode    = st_r.ctrl[`CTRL_EXT_BIT]; // RULE16
  assign high_rate   = is_high_rate(st_r.ctrl[`CTRL_RATE_MSB:`CTRL_RATE_LSB]);
  assign req         = wb_cyc_in && wb_stb_in && !st_r.ack;
  assign minute_last = ext_mode ? 24'(MINUTE_TICKS_EXT - 1) : 24'(MINUTE_TICKS_INT - 1);
  assign sym_last    = sym_period(ext_mode, high_rate) - 8'h01; // RULE12
  assign minute_ev   = osc_tick && (st_r.minute_cnt >= minute_last);
  assign sym_ev      = osc_tick && (st_r.sym_cnt >= sym_last);

  always_comb begin
    state_word = '0;
    state_word[`ST_LINES_MSB:`ST_LINES_LSB] = seq_bus.lines;
    state_word[`ST_BUSY_BIT]                = seq_bus.busy;
    state_word[`ST_LOW_BAT_BIT]             = st_r.lb_sync[1];
    state_word[`ST_SYM_MSB:`ST_SYM_LSB]     = st_r.symbol;
    state_word[`ST_EXT_BIT]                 = ext_mode;
    state_word[`ST_EDGES_MSB:`ST_EDGES_LSB] = st_r.edges;
  end

  always_comb begin
    events = '0;
    events[`IRQ_SEQ_DONE_BIT] = seq_bus.done;
    events[`IRQ_LOW_BAT_BIT]  = seq_bus.low_bat_hit; // RULE3
    events[`IRQ_MINUTE_BIT]   = minute_ev;
    events[`IRQ_SYMBOL_BIT]   = sym_ev && ext_mode;
  end

  // ====================
  // Register file, timers and pin sampling.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ack     = req;
    st_nxt.warm_go = 1'b0;
    st_nxt.shut_go = 1'b0;
    rd_clear       = '0;

    // Pins from outside the clock domain pass two flip-flops first.
    st_nxt.lb_sync  = {st_r.lb_sync[0], low_battery_input_in}; // RULE15
    st_nxt.msb_sync = {st_r.msb_sync[0], symbol_msb_input_in};
    st_nxt.lsb_sync = {st_r.lsb_sync[0], symbol_lsb_input_in};
    st_nxt.if_sync  = {st_r.if_sync[1:0], limited_if_input_in};

    if (req) begin
      st_nxt.rdata = '0;
      case (wb_adr_in)
        `ADR_CTRL: begin
          st_nxt.rdata[`CTRL_W-1:0] = st_r.ctrl;
          if (wb_we_in) begin
            st_nxt.ctrl = `CTRL_W'(merge_bytes(32'(st_r.ctrl), wb_dat_in, wb_sel_in));
          end
        end
        `ADR_SEQ_CMD: begin
          if (wb_we_in && wb_sel_in[0]) begin
            st_nxt.warm_go = wb_dat_in[`CMD_WARM_BIT];
            st_nxt.shut_go = wb_dat_in[`CMD_SHUT_BIT] && !wb_dat_in[`CMD_WARM_BIT];
          end
        end
        `ADR_STAGE_TIME: begin
          st_nxt.rdata[15:0] = st_r.stage_time;
          if (wb_we_in) begin
            st_nxt.stage_time = 16'(merge_bytes(32'(st_r.stage_time), wb_dat_in, wb_sel_in));
          end
        end
        `ADR_STATUS: begin
          st_nxt.rdata[`IRQ_W-1:0] = st_r.status;
          if (!wb_we_in) begin
            rd_clear = st_r.status;
          end
        end
        `ADR_MASK: begin
          st_nxt.rdata[`IRQ_W-1:0] = st_r.mask;
          if (wb_we_in) begin
            st_nxt.mask = `IRQ_W'(merge_bytes(32'(st_r.mask), wb_dat_in, wb_sel_in));
          end
        end
        `ADR_STATE: begin
          st_nxt.rdata = state_word;
        end
        `ADR_MINUTES: begin
          st_nxt.rdata[15:0] = st_r.minutes; // RULE4
        end
        `ADR_FILTER: begin
          st_nxt.rdata[7:0] = st_r.filt;
          if (wb_we_in) begin
            st_nxt.filt = 8'(merge_bytes(32'(st_r.filt), wb_dat_in, wb_sel_in)); // RULE9
          end
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // A new event in the cycle of a read still lands in the status.
    st_nxt.status = (st_r.status & ~rd_clear) | events;

    // Minute timebase counts oscillator ticks in either mode.
    if (osc_tick) begin
      if (minute_ev) begin
        st_nxt.minute_cnt = '0; // RULE4
        st_nxt.minutes    = st_r.minutes + 16'h0001;
      end else begin
        st_nxt.minute_cnt = st_r.minute_cnt + 24'h000001;
      end
    end

    // Symbol timing: sample the external symbol, or count IF transitions.
    if (st_r.if_sync[1] != st_r.if_sync[2] && !ext_mode) begin
      st_nxt.edge_acc = st_r.edge_acc + 12'h001; // RULE1
    end
    if (osc_tick) begin
      st_nxt.sym_cnt = sym_ev ? 8'h00 : st_r.sym_cnt + 8'h01; // RULE12
    end
    if (sym_ev) begin
      if (ext_mode) begin
        st_nxt.symbol = {st_r.msb_sync[1], st_r.lsb_sync[1]}; // RULE7 RULE14
      end
      st_nxt.edges    = st_r.edge_acc;
      st_nxt.edge_acc = '0;
    end

    // Each symbol rate has its own post-detection filter setting.
    st_nxt.filt_code = high_rate ? st_r.filt[`FILT_HIGH_MSB:`FILT_HIGH_LSB]
                                 : st_r.filt[`FILT_LOW_MSB:`FILT_LOW_LSB]; // RULE9
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r            <= '0;
      st_r.ctrl       <= `CTRL_RESET;
      st_r.filt       <= `FILT_RESET;
      st_r.stage_time <= `STAGE_TIME_RESET;
      st_r.status     <= `IRQ_RESET;
      st_r.mask       <= `IRQ_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ====================
  // Sequencer and reference clock.
  assign seq_bus.warm_go     = st_r.warm_go;
  assign seq_bus.shut_go     = st_r.shut_go;
  assign seq_bus.osc_tick    = osc_tick;
  assign seq_bus.ext_mode    = ext_mode; // RULE16
  assign seq_bus.low_bat     = st_r.lb_sync[1];
  assign seq_bus.stage_ticks = st_r.stage_time;

  rx_stage_sequencer u_seq (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .bus        (seq_bus.seq)
  );

  ref_clock_divider u_ref (
    .sys_clk_in          (sys_clk_in),
    .reset_n_in          (reset_n_in),
    .ext_mode_in         (ext_mode), // RULE16
    .ref_en_in           (st_r.ctrl[`CTRL_REF_EN_BIT]),
    .ref_sel40_in        (st_r.ctrl[`CTRL_REF40_BIT]),
    .osc_tick_out        (osc_tick),
    .reference_clock_out (reference_clock_output_out)
  );

  // ====================
  // Outputs.
  // The shared pin is driven only in external mode; otherwise it is the IF input.
  assign stage_zero_receiver_control_out    = seq_bus.lines[`STAGE_EXT_FIRST]; // RULE13
  assign stage_zero_receiver_control_oe_out = ext_mode; // RULE13
  assign receiver_stage_controls_out        = seq_bus.lines[7:1]; // RULE2 RULE8
  assign receiver_stage_controls_oe_out     = {7{1'b1}};
  assign wb_dat_out                         = st_r.rdata;
  assign wb_ack_out                         = st_r.ack;
  assign irq_out                            = |(st_r.status & st_r.mask);
  assign filter_bw_code_out                 = st_r.filt_code;

endmodule

/* File: rtl/ref_clock_divider.sv */
`timescale 1ns/1ps
`include "demod_regs.svh"
module ref_clock_divider (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic ext_mode_in,
  input  wire logic ref_en_in,
  input  wire logic ref_sel40_in,
  output logic      osc_tick_out,
  output logic      reference_clock_out
);

  typedef struct packed {
    logic [27:0] osc_acc;
    logic [19:0] frac_acc;
    logic        div;
    logic        ref_clk;
    logic        tick;
  } ref_s;

  ref_s        st_r;
  ref_s        st_nxt;
  logic [27:0] osc_sum;
  logic [19:0] frac_sum;

  // ==========================================================================
  // Oscillator tick emulation and reference clock division.
  // The oscillator is modelled as a tick enable from a phase accumulator, so
  // 76.8 kHz has a jitter of one system cycle against 100 MHz.
  always_comb begin
    st_nxt   = st_r;
    osc_sum  = st_r.osc_acc + (ext_mode_in ? `OSC_EXT_HZ : `OSC_INT_HZ);
    frac_sum = st_r.frac_acc + `REF_FRAC_HZ + `REF_FRAC_HZ;
    st_nxt.tick = 1'b0;
    if (osc_sum >= `SYS_HZ) begin
      st_nxt.osc_acc = osc_sum - `SYS_HZ;
      st_nxt.tick    = 1'b1;
    end else begin
      st_nxt.osc_acc = osc_sum;
    end
    if (!ref_en_in) begin
      st_nxt.ref_clk  = 1'b0; // RULE17
      st_nxt.div      = 1'b0;
      st_nxt.frac_acc = '0;
    end else if (st_r.tick) begin
      if (ext_mode_in) begin
        st_nxt.ref_clk = ~st_r.ref_clk; // RULE11 RULE17
      end else if (ref_sel40_in) begin
        st_nxt.div = ~st_r.div;
        if (st_r.div) begin
          st_nxt.ref_clk = ~st_r.ref_clk; // RULE6
        end
      end else if (frac_sum >= `REF_FRAC_MOD_HZ) begin
        st_nxt.frac_acc = frac_sum - `REF_FRAC_MOD_HZ;
        st_nxt.ref_clk  = ~st_r.ref_clk; // RULE6
      end else begin
        st_nxt.frac_acc = frac_sum;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign osc_tick_out        = st_r.tick;
  assign reference_clock_out = st_r.ref_clk;

endmodule

/* File: rtl/rx_stage_sequencer.sv */
`timescale 1ns/1ps
`include "demod_regs.svh"
module rx_stage_sequencer (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  rx_seq_if.seq     bus
);

  typedef struct packed {
    demod_pkg::seq_state_e state;
    logic [2:0]            stage;
    logic [15:0]           cnt;
    logic [7:0]            lines;
    logic                  done;
    logic                  hit;
  } seq_s;

  seq_s       st_r;
  seq_s       st_nxt;
  logic [2:0] first;
  logic       step;

  // ==========================================================================
  // Staged warm-up turns lines on lowest first; shutdown turns them off from
  // the top. Commands that arrive while a sequence runs are dropped.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    st_nxt.hit  = 1'b0;
    first = bus.ext_mode ? `STAGE_EXT_FIRST : `STAGE_INT_FIRST; // RULE2 RULE8
    step  = bus.osc_tick && (st_r.cnt + 16'h0001 >= bus.stage_ticks);
    case (st_r.state)
      demod_pkg::SEQ_IDLE: begin
        st_nxt.cnt = '0;
        if (bus.warm_go) begin
          st_nxt.state = demod_pkg::SEQ_WARM;
          st_nxt.stage = first;
        end else if (bus.shut_go) begin
          st_nxt.state = demod_pkg::SEQ_SHUT;
          st_nxt.stage = `STAGE_TOP;
        end
      end
      demod_pkg::SEQ_WARM, demod_pkg::SEQ_SHUT: begin
        if (bus.osc_tick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        if (step) begin
          st_nxt.cnt = '0;
          st_nxt.lines[st_r.stage] = (st_r.state == demod_pkg::SEQ_WARM);
          st_nxt.hit = bus.low_bat; // RULE3
          if ((st_r.state == demod_pkg::SEQ_WARM) ? (st_r.stage == `STAGE_TOP)
                                                  : (st_r.stage == first)) begin
            st_nxt.state = demod_pkg::SEQ_IDLE;
            st_nxt.done  = 1'b1;
          end else if (st_r.state == demod_pkg::SEQ_WARM) begin
            st_nxt.stage = st_r.stage + 3'h1;
          end else begin
            st_nxt.stage = st_r.stage - 3'h1;
          end
        end
      end
      default: begin
        st_nxt.state = demod_pkg::SEQ_IDLE;
      end
    endcase
    // The shared pin is an input in internal mode, so its stage stays off.
    if (!bus.ext_mode) begin
      st_nxt.lines[`STAGE_EXT_FIRST] = 1'b0; // RULE13
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.lines       = st_r.lines;
  assign bus.busy        = (st_r.state != demod_pkg::SEQ_IDLE);
  assign bus.done        = st_r.done;
  assign bus.low_bat_hit = st_r.hit;

endmodule
